// file: shared/rpfs_params.svh
// offsets, field positions, reset values and counts for the rx status block
`ifndef RPFS_PARAMS_SVH
`define RPFS_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define RPFS_OFF_CTRL 12'h000
`define RPFS_OFF_STATUS 12'h004
`define RPFS_OFF_LANE_STICKY 12'h008

// ****************************************************************
// field positions
// ****************************************************************
`define RPFS_CTRL_PARITY_EN_BIT 0
`define RPFS_CTRL_W1C_ALL_BIT 1
`define RPFS_STAT_SELF_BIT 0
`define RPFS_STAT_PARTNER_BIT 1
`define RPFS_STAT_EXCESS_BIT 2
`define RPFS_STAT_ALIGNED_BIT 3

// ****************************************************************
// reset values
// ****************************************************************
`define RPFS_CTRL_RESET 32'h00000001

// ****************************************************************
// partner fault detection counts
// ****************************************************************
`define RPFS_LF_THRESH 3'h4
`define RPFS_COL_WINDOW 8'h80

`endif

// file: shared/rpfs_pkg.sv
// types for the rx fault and lane parity status block
package rpfs_pkg;

  // one lane marker compare, presented for one cycle per marker
  typedef struct packed {
    logic valid;
    logic [7:0] rx_check;
    logic [7:0] calc_check;
  } rpfs_lane_t;

  // receive pcs condition inputs
  typedef struct packed {
    logic tx_test_pattern;
    logic lanes_aligned;
    logic ber_high;
    logic col_valid;
    logic lf_word;
  } rpfs_pcs_t;

  // partner fault detector, gray along idle-count-fault
  typedef enum logic [1:0] {
    RPFS_ST_IDLE = 2'h0,
    RPFS_ST_COUNT = 2'h1,
    RPFS_ST_FAULT = 2'h3
  } rpfs_state_t;

endpackage

// file: hw/rpfs_status.sv
// rx pcs fault, lane parity and excess error rate status with apb registers
`timescale 1ns/1ps
`include "rpfs_params.svh"

// Overview of operation
// R1 - self fault high while test pattern, misalignment or high error rate holds
// R2 - partner fault high once enough partner fault words arrive, while persisting
// R3 - lane parity error when received marker check byte differs from computed
// R4 - each lane error is a single cycle pulse, back to back allowed
// R5 - one independent parity error output per lane, lanes 0 through 19
// R6 - excess error rate flag is a level, high while error rate too high
// R7 - excess error rate flag usable directly as management status bit 3.32.1
// R8 - all status outputs synchronous to rx clock and low during reset
module rpfs_status #(
  parameter int LANES = 20
) (
  input wire logic i_clk,                        // rx clock
  input wire logic i_reset,                      // async reset, high
  input wire rpfs_pkg::rpfs_pcs_t i_pcs,         // pcs conditions
  input wire rpfs_pkg::rpfs_lane_t i_lane [LANES], // marker compares
  input wire logic i_psel,                       // apb select
  input wire logic i_penable,                    // apb enable
  input wire logic i_pwrite,                     // apb write
  input wire logic [11:0] i_paddr,               // apb byte address
  input wire logic [31:0] i_pwdata,              // apb write data
  output logic [31:0] o_prdata,                  // apb read data
  output logic o_pready,                         // apb ready
  output logic o_pslverr,                        // apb error
  output logic o_self_fault,                     // local fault level
  output logic o_partner_fault,                  // partner fault level
  output logic [LANES-1:0] o_lane_parity_err,    // per lane pulses
  output logic o_rx_excess_error_rate_flag       // high error rate level
);
  import rpfs_pkg::*;

  // elaboration check on lane count
  if (LANES < 1 || LANES > 32) begin : g_bad_lanes
    $error("rpfs_status: LANES must be 1 to 32");
  end

  // ****************************************************************
  // fault and error rate levels
  // ****************************************************************
  logic self_fault_ff;
  logic nxt_self_fault;
  logic excess_ff;
  logic nxt_excess;

  always_comb begin
    // R1 local fault causes
    nxt_self_fault = i_pcs.tx_test_pattern | ~i_pcs.lanes_aligned |
                     i_pcs.ber_high;
    // R6 level error rate flag
    nxt_excess = i_pcs.ber_high;
  end

  // R8 reset clears levels
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      self_fault_ff <= 1'b0;
      excess_ff <= 1'b0;
    end else begin
      self_fault_ff <= nxt_self_fault;
      excess_ff <= nxt_excess;
    end
  end

  // ****************************************************************
  // partner fault detector
  // ****************************************************************
  rpfs_state_t state_ff;
  rpfs_state_t nxt_state;
  logic [2:0] lf_cnt_ff;
  logic [2:0] nxt_lf_cnt;
  logic [7:0] col_cnt_ff;
  logic [7:0] nxt_col_cnt;
  logic partner_ff;
  logic nxt_partner;

  // R2 count fault words within a column window
  always_comb begin
    nxt_state = state_ff;
    nxt_lf_cnt = lf_cnt_ff;
    nxt_col_cnt = col_cnt_ff;
    case (state_ff)
      RPFS_ST_IDLE: begin
        if (i_pcs.col_valid && i_pcs.lf_word) begin
          nxt_state = RPFS_ST_COUNT;
          nxt_lf_cnt = 3'h1;
          nxt_col_cnt = 8'h00;
        end
      end
      RPFS_ST_COUNT: begin
        if (i_pcs.col_valid && i_pcs.lf_word) begin
          nxt_lf_cnt = lf_cnt_ff + 3'h1;
          nxt_col_cnt = 8'h00;
          if (lf_cnt_ff + 3'h1 >= `RPFS_LF_THRESH) begin
            nxt_state = RPFS_ST_FAULT;
          end
        end else if (i_pcs.col_valid) begin
          nxt_col_cnt = col_cnt_ff + 8'h01;
          if (col_cnt_ff + 8'h01 >= `RPFS_COL_WINDOW) begin
            nxt_state = RPFS_ST_IDLE;
            nxt_lf_cnt = 3'h0;
          end
        end
      end
      RPFS_ST_FAULT: begin
        if (i_pcs.col_valid && i_pcs.lf_word) begin
          nxt_col_cnt = 8'h00;
        end else if (i_pcs.col_valid) begin
          nxt_col_cnt = col_cnt_ff + 8'h01;
          if (col_cnt_ff + 8'h01 >= `RPFS_COL_WINDOW) begin
            nxt_state = RPFS_ST_IDLE;
            nxt_lf_cnt = 3'h0;
          end
        end
      end
      default: begin
        nxt_state = RPFS_ST_IDLE;
        nxt_lf_cnt = 3'h0;
        nxt_col_cnt = 8'h00;
      end
    endcase
    // R2 flag follows fault state
    nxt_partner = (nxt_state == RPFS_ST_FAULT);
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= RPFS_ST_IDLE;
      lf_cnt_ff <= 3'h0;
      col_cnt_ff <= 8'h00;
      partner_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      lf_cnt_ff <= nxt_lf_cnt;
      col_cnt_ff <= nxt_col_cnt;
      partner_ff <= nxt_partner;
    end
  end

  // ****************************************************************
  // lane parity compare
  // ****************************************************************
  logic [31:0] ctrl_ff;
  logic [LANES-1:0] lane_err_ff;
  logic [LANES-1:0] nxt_lane_err;

  // R5 one compare per lane
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_comb begin
      // R3 mismatch flags error
      nxt_lane_err[g] = ctrl_ff[`RPFS_CTRL_PARITY_EN_BIT] &
                        i_lane[g].valid &
                        (i_lane[g].rx_check != i_lane[g].calc_check);
    end
  end

  // R4 one cycle per marker
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      lane_err_ff <= '0;
    end else begin
      lane_err_ff <= nxt_lane_err;
    end
  end

  // ****************************************************************
  // apb registers
  // ****************************************************************
  logic [31:0] nxt_ctrl;
  logic [LANES-1:0] sticky_ff;
  logic [LANES-1:0] nxt_sticky;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic wr_take;
  logic mapped;
  logic [31:0] status_word;
  logic [31:0] sticky_word;

  always_comb begin
    wr_take = i_psel & i_penable & pready_ff & i_pwrite;
    mapped = (i_paddr == `RPFS_OFF_CTRL) | (i_paddr == `RPFS_OFF_STATUS) |
             (i_paddr == `RPFS_OFF_LANE_STICKY);
    status_word = 32'h00000000;
    status_word[`RPFS_STAT_SELF_BIT] = self_fault_ff;
    status_word[`RPFS_STAT_PARTNER_BIT] = partner_ff;
    // R7 management status source
    status_word[`RPFS_STAT_EXCESS_BIT] = excess_ff;
    status_word[`RPFS_STAT_ALIGNED_BIT] = i_pcs.lanes_aligned;
    sticky_word = 32'h00000000;
    sticky_word[LANES-1:0] = sticky_ff;
    nxt_ctrl = ctrl_ff;
    if (wr_take && i_paddr == `RPFS_OFF_CTRL) begin
      nxt_ctrl = i_pwdata & 32'h00000003;
    end
    // write one clears, new errors win
    nxt_sticky = sticky_ff;
    if (wr_take && i_paddr == `RPFS_OFF_LANE_STICKY) begin
      nxt_sticky = sticky_ff & ~i_pwdata[LANES-1:0];
    end
    if (wr_take && i_paddr == `RPFS_OFF_CTRL &&
        i_pwdata[`RPFS_CTRL_W1C_ALL_BIT]) begin
      nxt_sticky = '0;
    end
    nxt_sticky = nxt_sticky | lane_err_ff;
    nxt_pready = i_psel & i_penable & ~pready_ff;
    nxt_pslverr = nxt_pready & ~mapped;
    nxt_prdata = 32'h00000000;
    if (nxt_pready && !i_pwrite) begin
      case (i_paddr)
        `RPFS_OFF_CTRL: nxt_prdata = ctrl_ff;
        `RPFS_OFF_STATUS: nxt_prdata = status_word;
        `RPFS_OFF_LANE_STICKY: nxt_prdata = sticky_word;
        default: nxt_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_ff <= `RPFS_CTRL_RESET;
      sticky_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      sticky_ff <= nxt_sticky;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // R8 outputs straight from flops
  always_comb begin
    o_self_fault = self_fault_ff;
    o_partner_fault = partner_ff;
    o_lane_parity_err = lane_err_ff;
    o_rx_excess_error_rate_flag = excess_ff;
    o_prdata = prdata_ff;
    o_pready = pready_ff;
    o_pslverr = pslverr_ff;
  end

endmodule // rpfs_status

// file: tb/rpfs_status_chk.sv
// port assertions for the rx status block
`timescale 1ns/1ps
module rpfs_status_chk #(
  parameter int LANES = 20
) (
  input wire logic i_clk,                          // rx clock
  input wire logic i_reset,                        // async reset
  input wire rpfs_pkg::rpfs_pcs_t i_pcs,           // pcs conditions
  input wire rpfs_pkg::rpfs_lane_t i_lane [LANES], // compares
  input wire logic i_psel,                         // apb select
  input wire logic i_penable,                      // apb enable
  input wire logic o_pready,                       // apb ready
  input wire logic o_pslverr,                      // apb error
  input wire logic o_self_fault,                   // local fault
  input wire logic o_partner_fault,                // partner fault
  input wire logic [LANES-1:0] o_lane_parity_err,  // lane pulses
  input wire logic o_rx_excess_error_rate_flag     // rate flag
);
  import rpfs_pkg::*;
  logic up_ff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ****
  // checks
  // ****
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) up_ff <= 1'b0;
    else up_ff <= 1'b1;
  end
  chk_self_cause: assert property (up_ff |-> o_self_fault ==
    $past(i_pcs.tx_test_pattern | !i_pcs.lanes_aligned | i_pcs.ber_high))
    else $error("self fault level wrong");
  chk_rate_level: assert property (up_ff |->
    o_rx_excess_error_rate_flag == $past(i_pcs.ber_high))
    else $error("rate flag level wrong");
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    chk_lane_cause: assert property (o_lane_parity_err[g] |->
      $past(i_lane[g].valid && i_lane[g].rx_check != i_lane[g].calc_check))
      else $error("lane pulse without mismatch");
  end
  chk_partner_rise: assert property ($rose(o_partner_fault) |->
    $past(i_pcs.col_valid & i_pcs.lf_word))
    else $error("partner fault rose without word");
  chk_reset_quiet: assert property (!up_ff |-> !o_self_fault &&
    !o_partner_fault && o_lane_parity_err == '0 &&
    !o_rx_excess_error_rate_flag) else $error("output set after reset");
  chk_ready_once: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  chk_ready_time: assert property (i_psel && i_penable && !o_pready
    |=> o_pready) else $error("ready late");
  chk_error_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
endmodule // rpfs_status_chk
bind rpfs_status rpfs_status_chk #(.LANES(LANES)) i_rpfs_status_chk (
  .i_clk, .i_reset, .i_pcs, .i_lane, .i_psel, .i_penable, .o_pready,
  .o_pslverr, .o_self_fault, .o_partner_fault, .o_lane_parity_err,
  .o_rx_excess_error_rate_flag);

// file: tb/rpfs_partner_model.sv
// link partner model: one decoded column per cycle
`timescale 1ns/1ps
module rpfs_partner_model (
  input wire logic i_send_lf, // send fault words
  output logic o_col_valid,   // column strobe
  output logic o_lf_word      // fault word seen
);
  assign o_col_valid = 1'b1;
  assign o_lf_word = i_send_lf;
endmodule // rpfs_partner_model

// file: tb/rpfs_status_bench.sv
// self-checking bench for the rx status block
`timescale 1ns/1ps
`include "rpfs_params.svh"
module rpfs_status_bench;
  import rpfs_pkg::*;
  logic clk, rst, send_lf, col, lf, psel, pen, pwr, rdy, err, sf, pf, hb, e;
  logic [2:0] ctl;
  logic [11:0] pa;
  logic [31:0] pwd, prd, rd;
  logic [19:0] lpe;
  rpfs_lane_t lane [20];
  int bad_count, check_count, i;
  // {test, aligned, ber, self, rate}
  logic [4:0] rows [8] = '{5'h02, 5'h07, 5'h08, 5'h0F, 5'h12, 5'h17,
    5'h1A, 5'h1F};
  rpfs_partner_model i_rpfs_partner_model (.i_send_lf(send_lf),
    .o_col_valid(col), .o_lf_word(lf));
  rpfs_status i_rpfs_status (.i_clk(clk), .i_reset(rst),
    .i_pcs({ctl, col, lf}), .i_lane(lane), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(err), .o_self_fault(sf),
    .o_partner_fault(pf), .o_lane_parity_err(lpe),
    .o_rx_excess_error_rate_flag(hb));
  // ****
  // tasks
  // ****
  task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic chk_bit(input logic g, input logic x);
    chk_word({31'h0, g}, {31'h0, x});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    rd = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      give_verdict;
    end
    @(posedge clk);
  endtask
  task automatic lanes(input logic [7:0] odd, input logic [7:0] even);
    for (int k = 0; k < 20; k++) lane[k] <= '{1'b1, 8'h5A, k[0] ? odd : even};
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {ctl, send_lf, psel, pen, pwr, pa, pwd} = '0;
    bad_count = 0;
    check_count = 0;
    for (i = 0; i < 20; i++) lane[i] = '0;
    tick(5);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      ctl <= rows[i][4:2];
      tick(2);
      chk_bit(sf, rows[i][1]);
      chk_bit(hb, rows[i][0]);
      apb(1'b0, `RPFS_OFF_STATUS, '0);
      chk_word(rd[3:0], {rows[i][3], rows[i][0], 1'b0, rows[i][1]});
    end
    $display("levels test done");
    ctl <= 3'b010;
    lanes(8'h5A, 8'hA5);
    tick(1);
    lanes(8'hC3, 8'h5A);
    tick(1);
    for (i = 0; i < 20; i++) lane[i] <= '0;
    chk_word(lpe, 20'h55555);
    tick(1);
    chk_word(lpe, 20'hAAAAA);
    tick(1);
    chk_word(lpe, 20'h0);
    apb(1'b0, `RPFS_OFF_LANE_STICKY, '0);
    chk_word(rd, 32'h000FFFFF);
    apb(1'b1, `RPFS_OFF_LANE_STICKY, 32'h0000000F);
    apb(1'b0, `RPFS_OFF_LANE_STICKY, '0);
    chk_word(rd, 32'h000FFFF0);
    apb(1'b1, `RPFS_OFF_CTRL, 32'h0);
    lanes(8'h00, 8'h00);
    tick(1);
    for (i = 0; i < 20; i++) lane[i] <= '0;
    tick(1);
    chk_word(lpe, 20'h0);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    chk_bit(e, 1'b1);
    apb(1'b0, `RPFS_OFF_CTRL, '0);
    chk_word(rd, 32'h0);
    apb(1'b1, `RPFS_OFF_CTRL, 32'h00000002);
    apb(1'b0, `RPFS_OFF_LANE_STICKY, '0);
    chk_word(rd, 32'h0);
    apb(1'b0, `RPFS_OFF_CTRL, '0);
    chk_word(rd, 32'h00000002);
    $display("lane test done");
    send_lf <= 1'b1;
    tick(3);
    send_lf <= 1'b0;
    tick(5);
    chk_bit(pf, 1'b0);
    send_lf <= 1'b1;
    tick(1);
    send_lf <= 1'b0;
    tick(2);
    chk_bit(pf, 1'b1);
    apb(1'b0, `RPFS_OFF_STATUS, '0);
    chk_word(rd[3:0], 4'hA);
    tick(120);
    chk_bit(pf, 1'b1);
    tick(10);
    chk_bit(pf, 1'b0);
    $display("partner test done");
    ctl <= 3'b011;
    tick(2);
    chk_bit(sf & hb, 1'b1);
    rst <= 1'b1;
    tick(1);
    chk_bit(sf | hb, 1'b0);
    rst <= 1'b0;
    tick(1);
    apb(1'b0, `RPFS_OFF_CTRL, '0);
    chk_word(rd, `RPFS_CTRL_RESET);
    $display("reset test done");
    give_verdict;
  end
endmodule // rpfs_status_bench
